// [rtl/swp_pkg.sv]
// Constants, types and helpers for the scan programmed watchpoint unit.
// Assumes one system clock; test pins are sampled into that clock domain.
package swp_pkg;

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    SEL_DR = 16'h0004,
    CAP_DR = 16'h0008,
    SHIFT_DR = 16'h0010,
    EXIT1_DR = 16'h0020,
    PAUSE_DR = 16'h0040,
    EXIT2_DR = 16'h0080,
    UPD_DR = 16'h0100,
    SEL_IR = 16'h0200,
    CAP_IR = 16'h0400,
    SHIFT_IR = 16'h0800,
    EXIT1_IR = 16'h1000,
    PAUSE_IR = 16'h2000,
    EXIT2_IR = 16'h4000,
    UPD_IR = 16'h8000
  } swp_tap_t;

  // Instruction codes and scan chain numbers
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SCAN_N = 4'h2;
  localparam logic [3:0] IR_INTEST = 4'hc;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] CHAIN_WATCH = 4'h2;
  localparam logic [3:0] CHAIN_BOUNDARY = 4'h3;
  localparam logic [3:0] SEL_RESET = 4'h3;

  // Programming chain layout
  localparam int WCH_LEN = 38;
  localparam int WCH_ADDR_LSB = 32;
  localparam int WCH_RW_BIT = 37;

  // Register addresses: bits [4:3] pick the group, bits [2:0] the register
  localparam logic [4:0] ADDR_DBG_CTRL = 5'h00;
  localparam logic [4:0] ADDR_DBG_STAT = 5'h01;
  localparam logic [1:0] GRP_WP0 = 2'h1;
  localparam logic [1:0] GRP_WP1 = 2'h2;
  localparam logic [2:0] WP_AV = 3'h0;
  localparam logic [2:0] WP_AM = 3'h1;
  localparam logic [2:0] WP_DV = 3'h2;
  localparam logic [2:0] WP_DM = 3'h3;
  localparam logic [2:0] WP_CV = 3'h4;
  localparam logic [2:0] WP_CM = 3'h5;

  // Control value bit positions; bits 6:0 are also the mask layout
  localparam int CB_RANGE = 6;
  localparam int CB_CHAIN = 5;
  localparam int CB_ENABLE = 7;

  localparam int DC_HALT_REQ = 0;
  localparam int DC_WP_DISABLE = 1;
  localparam logic [2:0] DC_RESET = 3'h0;

  // Boundary chain: data 0..31, control 32..64, address 31 down to 0 at 65..96
  localparam int BS_LEN = 97;
  localparam int BS_DATA_LSB = 0;
  localparam int BS_CTRL_LSB = 32;
  localparam int BS_ADDR_LSB = 65;

  typedef struct packed {
    logic [31:0] addr_val;
    logic [31:0] addr_mask;
    logic [31:0] data_val;
    logic [31:0] data_mask;
    logic [7:0] ctrl_val;
    logic [6:0] ctrl_mask;
  } swp_wp_t;

  localparam swp_wp_t WP_RESET = '0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic ntrans;
    logic nopc;
    logic nbw;
    logic nrw;
  } swp_core_bus_t;

  // Mask bit of one forces a match, zero demands equality
  function automatic logic masked_eq(logic [31:0] val, logic [31:0] mask, logic [31:0] in);
    masked_eq = &(~(val ^ in) | mask);
  endfunction : masked_eq

endpackage : swp_pkg

// [rtl/swp_unit.sv]
// Watchpoint unit with its test access port, programming chain and boundary chain.
// Assumes test pins and pad values are asynchronous; the core bus shares the clock.
`timescale 1ns/1ns
`default_nettype none
module swp_unit
  import swp_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire swp_core_bus_t core_bus,
  input wire logic [1:0] extern_cond,
  output logic core_halt_request,
  input wire logic [BS_LEN-1:0] bs_core_vec,
  input wire logic [BS_LEN-1:0] bs_pad_vec,
  output logic [BS_LEN-1:0] bs_test_out,
  output logic bs_drive_pads,
  output logic bs_drive_core
);

  logic rst_s1_q;
  logic rst_n_i;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic tck_prev_q;
  logic [BS_LEN-1:0] pad_s1_q;
  logic [BS_LEN-1:0] pad_s2_q;
  swp_tap_t tap_q;
  swp_tap_t tap_d;
  logic [3:0] ir_sh_q;
  logic [3:0] ir_q;
  logic [3:0] sel_sh_q;
  logic [3:0] sel_q;
  logic [WCH_LEN-1:0] wch_q;
  logic [4:0] rd_addr_q;
  logic [BS_LEN-1:0] bs_sh_q;
  logic [BS_LEN-1:0] bs_upd_q;
  logic byp_q;
  logic tdo_q;
  logic tdo_oe_q;
  swp_wp_t wp_q [2];
  logic [2:0] dbg_ctrl_q;
  logic chainout_q;
  logic halt_q;

  // Reset release and pin synchronisers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_i <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_i <= rst_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      tck_prev_q <= 1'b0;
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      pin_s1_q <= {tdi, tms, tck};
      pin_s2_q <= pin_s1_q;
      tck_prev_q <= pin_s2_q[0];
      pad_s1_q <= bs_pad_vec;
      pad_s2_q <= pad_s1_q;
    end
  end

  wire tck_s = pin_s2_q[0];
  wire tms_s = pin_s2_q[1];
  wire tdi_s = pin_s2_q[2];
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // TAP state sequence
  always_comb begin
    case (tap_q)
      TAP_RESET: tap_d = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_d = tms_s ? SEL_DR : TAP_IDLE;
      SEL_DR: tap_d = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: tap_d = tms_s ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_d = tms_s ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_d = tms_s ? UPD_DR : PAUSE_DR;
      PAUSE_DR: tap_d = tms_s ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_d = tms_s ? UPD_DR : SHIFT_DR;
      UPD_DR: tap_d = tms_s ? SEL_DR : TAP_IDLE;
      SEL_IR: tap_d = tms_s ? TAP_RESET : CAP_IR;
      CAP_IR: tap_d = tms_s ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_d = tms_s ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_d = tms_s ? UPD_IR : PAUSE_IR;
      PAUSE_IR: tap_d = tms_s ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_d = tms_s ? UPD_IR : SHIFT_IR;
      UPD_IR: tap_d = tms_s ? SEL_DR : TAP_IDLE;
      default: tap_d = TAP_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_q <= TAP_RESET;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // Data register selection
  wire is_intest = (ir_q == IR_INTEST);
  wire is_extest = (ir_q == IR_EXTEST);
  wire wch_sel = is_intest & (sel_q == CHAIN_WATCH);
  wire bs_sel = is_extest | (is_intest & (sel_q == CHAIN_BOUNDARY));
  wire scn_sel = (ir_q == IR_SCAN_N);
  wire byp_sel = ~(wch_sel | bs_sel | scn_sel);
  wire at_cap = tck_rise & (tap_q == CAP_DR);
  wire at_shift = tck_rise & (tap_q == SHIFT_DR);
  wire at_upd = tck_rise & (tap_q == UPD_DR);

  // Instruction and scan select registers
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q <= IR_BYPASS;
      sel_sh_q <= SEL_RESET;
      sel_q <= SEL_RESET;
      byp_q <= 1'b0;
    end else if (tck_rise) begin
      case (tap_q)
        TAP_RESET: begin
          ir_q <= IR_BYPASS;
          sel_q <= SEL_RESET;
        end
        CAP_IR: ir_sh_q <= IR_CAPTURE;
        SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
        UPD_IR: ir_q <= ir_sh_q;
        CAP_DR: begin
          sel_sh_q <= sel_q;
          byp_q <= 1'b0;
        end
        SHIFT_DR: begin
          if (scn_sel) sel_sh_q <= {tdi_s, sel_sh_q[3:1]};
          byp_q <= tdi_s;
        end
        UPD_DR: if (scn_sel) sel_q <= sel_sh_q;
        default: byp_q <= byp_q;
      endcase
    end
  end

  // Boundary chain
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bs_sh_q <= '0;
      bs_upd_q <= '0;
    end else if (bs_sel) begin
      if (at_cap) begin
        bs_sh_q <= is_intest ? bs_core_vec : pad_s2_q;
      end else if (at_shift) begin
        bs_sh_q <= {tdi_s, bs_sh_q[BS_LEN-1:1]};
      end else if (at_upd) begin
        bs_upd_q <= bs_sh_q;
      end
    end
  end

  // Programming chain decode
  wire [4:0] acc_addr = wch_q[WCH_RW_BIT-1:WCH_ADDR_LSB];
  wire [31:0] acc_data = wch_q[WCH_ADDR_LSB-1:0];
  wire acc_wr = at_upd & wch_sel & wch_q[WCH_RW_BIT];
  wire acc_rd = at_upd & wch_sel & ~wch_q[WCH_RW_BIT];
  wire [1:0] wr_grp = acc_addr[4:3];
  wire [2:0] wr_reg = acc_addr[2:0];
  wire [1:0] wr_wp = {acc_wr & (wr_grp == GRP_WP1), acc_wr & (wr_grp == GRP_WP0)};
  wire wr_ctrl = acc_wr & (acc_addr == ADDR_DBG_CTRL);

  // Match logic
  wire [1:0] ac_match;
  wire [1:0] dat_match;
  wire [1:0] wp_hit;
  wire [1:0] range_in = {1'b0, wp_hit[1]};
  wire [1:0] chain_in = {1'b0, chainout_q};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_wp
      wire [6:0] ctrl_in = {range_in[gi], chain_in[gi], extern_cond[gi],
                            core_bus.ntrans, core_bus.nopc, core_bus.nbw, core_bus.nrw};
      wire addr_ok = masked_eq(wp_q[gi].addr_val, wp_q[gi].addr_mask, core_bus.addr);
      wire ctrl_ok = masked_eq({25'h0, wp_q[gi].ctrl_val[6:0]},
                               {25'h1ffffff, wp_q[gi].ctrl_mask}, {25'h0, ctrl_in});
      assign ac_match[gi] = addr_ok & ctrl_ok;
      assign dat_match[gi] = masked_eq(wp_q[gi].data_val, wp_q[gi].data_mask, core_bus.data);
      assign wp_hit[gi] = ac_match[gi] & dat_match[gi] & wp_q[gi].ctrl_val[CB_ENABLE];
    end
  endgenerate

  wire halt_d = (|wp_hit & ~dbg_ctrl_q[DC_WP_DISABLE]) | dbg_ctrl_q[DC_HALT_REQ];
  wire [3:0] dbg_stat = {chainout_q, wp_hit[1], wp_hit[0], halt_q};

  // Register read selection
  wire [2:0] rd_reg = rd_addr_q[2:0];
  wire [1:0] rd_grp = rd_addr_q[4:3];
  wire rd_wp_ok = (rd_grp == GRP_WP0) | (rd_grp == GRP_WP1);
  wire swp_wp_t rd_wp = (rd_grp == GRP_WP1) ? wp_q[1] : wp_q[0];
  wire [31:0] rd_wp_word =
    (rd_reg == WP_AV) ? rd_wp.addr_val :
    (rd_reg == WP_AM) ? rd_wp.addr_mask :
    (rd_reg == WP_DV) ? rd_wp.data_val :
    (rd_reg == WP_DM) ? rd_wp.data_mask :
    (rd_reg == WP_CV) ? {24'h0, rd_wp.ctrl_val} :
    (rd_reg == WP_CM) ? {25'h0, rd_wp.ctrl_mask} : 32'h0;
  wire [31:0] rd_data =
    (rd_addr_q == ADDR_DBG_CTRL) ? {29'h0, dbg_ctrl_q} :
    (rd_addr_q == ADDR_DBG_STAT) ? {28'h0, dbg_stat} :
    rd_wp_ok ? rd_wp_word : 32'h0;

  // Programming chain: data field reloads with the pending read value
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wch_q <= '0;
      rd_addr_q <= ADDR_DBG_CTRL;
    end else if (wch_sel) begin
      if (at_cap) begin
        wch_q[WCH_ADDR_LSB-1:0] <= rd_data;
      end else if (at_shift) begin
        wch_q <= {tdi_s, wch_q[WCH_LEN-1:1]};
      end else if (acc_rd) begin
        rd_addr_q <= acc_addr;
      end
    end
  end

  // Watchpoint and global registers
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q[0] <= WP_RESET;
      wp_q[1] <= WP_RESET;
      dbg_ctrl_q <= DC_RESET;
    end else begin
      if (wr_ctrl) dbg_ctrl_q <= acc_data[2:0];
      for (int i = 0; i < 2; i++) begin
        if (wr_wp[i]) begin
          case (wr_reg)
            WP_AV: wp_q[i].addr_val <= acc_data;
            WP_AM: wp_q[i].addr_mask <= acc_data;
            WP_DV: wp_q[i].data_val <= acc_data;
            WP_DM: wp_q[i].data_mask <= acc_data;
            WP_CV: wp_q[i].ctrl_val <= acc_data[7:0];
            WP_CM: wp_q[i].ctrl_mask <= acc_data[6:0];
            default: wp_q[i].ctrl_mask <= wp_q[i].ctrl_mask;
          endcase
        end
      end
    end
  end

  // Chain latch of watchpoint 1 and halt output
  wire chain_clr = wr_wp[1] & (wr_reg == WP_CV);
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chainout_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      if (chain_clr) chainout_q <= 1'b0;
      else if (ac_match[1]) chainout_q <= dat_match[1];
      halt_q <= halt_d;
    end
  end

  // Serial output changes on the falling test clock
  wire in_shift = (tap_q == SHIFT_DR) | (tap_q == SHIFT_IR);
  wire dr_bit = byp_sel ? byp_q : wch_sel ? wch_q[0] : bs_sel ? bs_sh_q[0] : sel_sh_q[0];
  wire tdo_src = (tap_q == SHIFT_IR) ? ir_sh_q[0] : dr_bit;
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tdo_src;
      tdo_oe_q <= in_shift;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign core_halt_request = halt_q;
  assign bs_test_out = bs_upd_q;
  assign bs_drive_pads = is_extest;
  assign bs_drive_core = is_intest & ~wch_sel;

endmodule : swp_unit
`default_nettype wire

// [sim/swp_unit_props.sv]
// Port checker for the watchpoint unit.
// Assumes it is bound to swp_unit; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module swp_unit_props
  import swp_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic core_halt_request,
  input wire logic [BS_LEN-1:0] bs_test_out,
  input wire logic bs_drive_pads,
  input wire logic bs_drive_core
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck)) else $error("oe moved off tck fall");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck)) else $error("tdo moved off tck fall");
  a_oe_holds: assert property ($rose(tdo_oe) |=> tdo_oe [*6]) else $error("oe dropped early");
  a_reset_quiet: assert property ($rose(reset_n) |-> !(tdo_oe | bs_drive_pads | bs_drive_core | core_halt_request))
    else $error("outputs busy after reset");
  a_cells_on_rise: assert property ($changed(bs_test_out) |-> $past(tck)) else $error("cells moved off tck rise");
  a_pads_on_rise: assert property ($changed(bs_drive_pads) |-> $past(tck)) else $error("pad drive off tck rise");
  a_core_on_rise: assert property ($changed(bs_drive_core) |-> $past(tck)) else $error("core drive off tck rise");
  a_drive_excl: assert property (!(bs_drive_pads && bs_drive_core)) else $error("both drive modes on");
endmodule : swp_unit_props
`default_nettype wire

// [sim/swp_host.sv]
// Debug host model: drives the test pins and shifts words LSB first.
// Assumes the unit's clock for pacing; tck stands low between frames.
`timescale 1ns/1ns
`default_nettype none
module swp_host
  import swp_pkg::*;
(
  input wire logic clock,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One tck period of 4 clocks low, 4 high; tdo taken just before the fall
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clock);
    #1;
    tck = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    q = tdo;
    tck = 1'b0;
  endtask : step
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : tap_reset
  task automatic scan(input logic ir, input logic [BS_LEN-1:0] din, input int n, output logic [BS_LEN-1:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    repeat (4) @(posedge clock);
    #1;
  endtask : scan
endmodule : swp_host
`default_nettype wire

// [sim/test_scan_programmed_watchpoint_unit.sv]
// Bench for the watchpoint unit: scan access, matching, boundary cells.
// Assumes the host model drives the test pins.
`timescale 1ns/1ns
`default_nettype none
module test_scan_programmed_watchpoint_unit
  import swp_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, core_halt_request, bs_drive_pads, bs_drive_core;
  swp_core_bus_t core_bus = '0;
  logic [1:0] extern_cond = 2'h0;
  logic [BS_LEN-1:0] bs_core_vec = '0;
  logic [BS_LEN-1:0] bs_pad_vec = '0;
  logic [BS_LEN-1:0] bs_test_out, dout;
  int errors = 0;
  int compares = 0;
  always #50 clock = ~clock;
  swp_unit swp_unit_i (.clock, .reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe, .core_bus, .extern_cond,
    .core_halt_request, .bs_core_vec, .bs_pad_vec, .bs_test_out, .bs_drive_pads, .bs_drive_core);
  swp_host swp_host_i (.clock, .tck, .tms, .tdi, .tdo);
  task automatic conclude();
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [BS_LEN-1:0] want, input logic [BS_LEN-1:0] got);
    compares++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, want, got);
    end
  endtask : chk
  task automatic scan(input logic ir, input logic [BS_LEN-1:0] din, input int n);
    swp_host_i.scan(ir, din, n, dout);
  endtask : scan
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    scan(1'b0, BS_LEN'({1'b1, a, d}), WCH_LEN);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] want);
    scan(1'b0, BS_LEN'({1'b0, a, 32'hffff_ffff}), WCH_LEN);
    scan(1'b0, BS_LEN'({1'b0, a, 32'h0}), WCH_LEN);
    chk($sformatf("reg %h", a), BS_LEN'(want), BS_LEN'(dout[31:0]));
    chk("tdo drive idle", BS_LEN'(1'b0), BS_LEN'(tdo_oe));
  endtask : rd
  task automatic sel(input logic [3:0] c);
    scan(1'b1, BS_LEN'(IR_SCAN_N), 4);
    chk("ir capture", BS_LEN'(IR_CAPTURE), dout);
    scan(1'b0, BS_LEN'(c), 4);
    scan(1'b1, BS_LEN'(IR_INTEST), 4);
  endtask : sel
  task automatic bus(input logic [31:0] a, input logic o, input logic [31:0] d, input logic [1:0] x, input logic e);
    core_bus = {a, d, 1'b0, o, 2'h0};
    extern_cond = x;
    repeat (3) @(posedge clock);
    #1;
    chk("halt", BS_LEN'(e), BS_LEN'(core_halt_request));
  endtask : bus
  // Unmapped slots read zero; narrow registers keep only their low bits
  function automatic logic [31:0] reg_exp(input logic [4:0] a);
    logic [31:0] m;
    m = a[2:0] == 3'h4 ? 32'hff : a[2:0] == 3'h5 ? 32'h7f : 32'hffff_ffff;
    reg_exp = a[2:0] > 3'h5 ? 32'h0 : (32'h5ac3_96e1 ^ {27'h0, a}) & m;
  endfunction : reg_exp
  initial begin
    #6_000_000;
    errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    swp_host_i.tap_reset();
    sel(CHAIN_WATCH);
    rd(ADDR_DBG_CTRL, 32'h0);
    for (int i = 8; i < 22; i++) wr(5'(i), 32'h5ac3_96e1 ^ 32'(i));
    for (int i = 8; i < 22; i++) rd(5'(i), reg_exp(5'(i)));
    wr(5'h11, 32'h0);
    wr(5'h14, 32'h0);
    wr(5'h0c, 32'h0);
    wr(ADDR_DBG_CTRL, 32'hffff_fffa);
    rd(ADDR_DBG_CTRL, 32'h2);
    wr(ADDR_DBG_STAT, 32'hf);
    rd(ADDR_DBG_STAT, 32'h0);
    wr(ADDR_DBG_CTRL, 32'h0);
    wr(5'h08, 32'h0000_1000);
    wr(5'h09, 32'h3);
    wr(5'h0b, 32'hffff_ffff);
    wr(5'h0d, 32'h6b);
    wr(5'h0c, 32'h90);
    bus(32'h1002, 1'b0, 32'h0, 2'h1, 1'b1);
    bus(32'h1004, 1'b0, 32'h0, 2'h1, 1'b0);
    bus(32'h1000, 1'b0, 32'h0, 2'h2, 1'b0);
    wr(5'h0a, 32'he1a0_0000);
    wr(5'h0b, 32'h0);
    bus(32'h1000, 1'b0, 32'he1a0_0000, 2'h1, 1'b1);
    bus(32'h1000, 1'b0, 32'he1a0_0001, 2'h1, 1'b0);
    wr(5'h0c, 32'h94);
    bus(32'h1000, 1'b1, 32'he1a0_0000, 2'h1, 1'b1);
    wr(5'h0c, 32'h14);
    bus(32'h1000, 1'b1, 32'he1a0_0000, 2'h1, 1'b0);
    wr(ADDR_DBG_CTRL, 32'h1);
    bus(32'h0, 1'b0, 32'h0, 2'h0, 1'b1);
    scan(1'b1, BS_LEN'(IR_BYPASS), 4);
    scan(1'b0, BS_LEN'(4'hb), 4);
    chk("bypass", BS_LEN'(4'h6), dout);
    bs_pad_vec = 97'h1_f0e1_d2c3_b4a5_9687_7869_5a4b;
    bs_core_vec = 97'h0_0f1e_2d3c_4b5a_6978_8796_a5b4;
    scan(1'b1, BS_LEN'(IR_EXTEST), 4);
    chk("drive modes", BS_LEN'(2'h2), BS_LEN'({bs_drive_pads, bs_drive_core}));
    scan(1'b0, bs_core_vec, BS_LEN);
    chk("pad capture", bs_pad_vec, dout);
    chk("cell update", bs_core_vec, bs_test_out);
    sel(CHAIN_BOUNDARY);
    chk("drive modes", BS_LEN'(2'h1), BS_LEN'({bs_drive_pads, bs_drive_core}));
    scan(1'b0, bs_pad_vec, BS_LEN);
    chk("core capture", bs_core_vec, dout);
    chk("cell update", bs_pad_vec, bs_test_out);
    conclude();
  end
endmodule : test_scan_programmed_watchpoint_unit
bind swp_unit swp_unit_props swp_unit_props_i (.clock, .reset_n, .tck, .tdo, .tdo_oe, .core_halt_request,
  .bs_test_out, .bs_drive_pads, .bs_drive_core);
`default_nettype wire
